// ---- lahr_top.sv ----
/*
 holds the l1 reject hold-off timer of one switch port: register file,
 request sequencer and the event counters.
 assumes the link layer gives same-clock one-cycle pulses for each received
 l1 request DLLP and for each ack or nak the port sends.
*/
`timescale 1ns/100ps
module lahr_top
   import lahr_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [lahr_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [lahr_pkg::DATA_W-1:0] wb_dat_i,
   input  wire logic [3:0]                  wb_sel_i,
   output logic      [lahr_pkg::DATA_W-1:0] wb_dat_o,
   output logic                             wb_ack_o,
   input  wire logic                        l1_req_dllp_i,
   input  wire logic                        pm_ack_sent_i,
   input  wire logic                        pm_nak_sent_i,
   output logic                             l1_entry_req_o,
   output logic                             holdoff_o,
   output logic                             dllp_ignored_o
);
   import lahr_pkg::*;

   // =====================================================
   // carriers and sub-blocks
   lahr_reg_if rb ();
   lahr_tmr_if tif ();

   lahr_wb_slave u_wb (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_dat_i (wb_dat_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .rb       (rb)
   );

   lahr_holdoff_cnt u_cnt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tif   (tif)
   );

   // =====================================================
   // register state
   logic [LIMIT_W-1:0] limit_reg;
   logic               mode_reg;
   logic [REJ_W-1:0]   rej_cnt_reg;
   logic [EV_W-1:0]    ign_cnt_reg;
   logic [EV_W-1:0]    rst_cnt_reg;

   logic wr_ctrl;
   logic wr_evnt;

   assign wr_ctrl = rb.wr & (rb.addr == CTRL_OFS);
   assign wr_evnt = rb.wr & (rb.addr == EVNT_OFS);

   // =====================================================
   // control register with byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_reg <= LIMIT_RST;
      end else if (wr_ctrl) begin
         if (rb.sel[0]) begin
            limit_reg[7:0] <= rb.wdata[LIMIT_LSB +: 8];
         end
         if (rb.sel[1]) begin
            limit_reg[13:8] <= rb.wdata[LIMIT_LSB+8 +: 6];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_RST;
      end else if (wr_ctrl & rb.sel[2]) begin
         mode_reg <= rb.wdata[MODE_BIT];
      end
   end

   // =====================================================
   // request sequencer
   lahr_state_t state_reg;
   lahr_state_t state_next;
   logic        fresh_req;
   logic        restart;
   logic        ignored;
   logic        reject;

   // a DLLP that meets expiry is taken as fresh, not as a restart
   always_comb begin
      state_next = state_reg;
      fresh_req  = 1'b0;
      restart    = 1'b0;
      ignored    = 1'b0;
      reject     = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (l1_req_dllp_i) begin
               fresh_req  = 1'b1;
               state_next = ST_PEND;
            end
         end
         ST_PEND: begin
            if (pm_nak_sent_i) begin
               reject     = 1'b1;
               state_next = ST_HOLD;
            end else if (pm_ack_sent_i) begin
               state_next = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (tif.expired) begin
               if (l1_req_dllp_i) begin
                  fresh_req  = 1'b1;
                  state_next = ST_PEND;
               end else begin
                  state_next = ST_IDLE;
               end
            end else if (l1_req_dllp_i) begin
               if (mode_reg) begin
                  ignored = 1'b1;
               end else begin
                  restart = 1'b1;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // both modes start at the nak; only mode 0 restarts
   assign tif.start = reject | restart;
   assign tif.run   = (state_reg == ST_HOLD);
   assign tif.limit = limit_reg;

   // =====================================================
   // outputs toward the link layer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         l1_entry_req_o <= 1'b0;
         dllp_ignored_o <= 1'b0;
      end else begin
         l1_entry_req_o <= fresh_req;
         dllp_ignored_o <= ignored | restart;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         holdoff_o <= 1'b0;
      end else begin
         holdoff_o <= (state_next == ST_HOLD);
      end
   end

   // =====================================================
   // event counters; a count in the clearing cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rej_cnt_reg <= '0;
      end else if (reject) begin
         rej_cnt_reg <= rej_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ign_cnt_reg <= '0;
      end else if (ignored) begin
         ign_cnt_reg <= wr_evnt ? 16'h0001 : sat_inc(ign_cnt_reg);
      end else if (wr_evnt) begin
         ign_cnt_reg <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_cnt_reg <= '0;
      end else if (restart) begin
         rst_cnt_reg <= wr_evnt ? 16'h0001 : sat_inc(rst_cnt_reg);
      end else if (wr_evnt) begin
         rst_cnt_reg <= '0;
      end
   end

   // =====================================================
   // read mux; unmapped and reserved bits read zero
   always_comb begin
      rb.rdata = '0;
      unique case (rb.addr)
         CTRL_OFS: begin
            rb.rdata[LIMIT_LSB +: LIMIT_W] = limit_reg;
            rb.rdata[MODE_BIT]             = mode_reg;
         end
         STAT_OFS: begin
            rb.rdata[ST_HOLD_BIT]            = (state_reg == ST_HOLD);
            rb.rdata[ST_FSM_LSB +: 2]        = state_reg;
            rb.rdata[ST_ELAP_LSB +: LIMIT_W] = tif.elapsed;
            rb.rdata[ST_REJ_LSB +: REJ_W]    = rej_cnt_reg;
         end
         EVNT_OFS: begin
            rb.rdata[0 +: EV_W]          = ign_cnt_reg;
            rb.rdata[EV_RST_LSB +: EV_W] = rst_cnt_reg;
         end
         default: begin
            rb.rdata = '0;
         end
      endcase
   end
endmodule : lahr_top

// ---- lahr_pkg.sv ----
/*
 holds the constants, state codes and helpers of the l1 reject hold-off timer.
 assumes a 20 MHz clock and a 32-bit classic wishbone register bus.
*/
package lahr_pkg;
   // =====================================================
   // bus and register map
   localparam int unsigned ADDR_W   = 12;
   localparam int unsigned DATA_W   = 32;
   localparam logic [11:0] CTRL_OFS = 12'h710;
   localparam logic [11:0] STAT_OFS = 12'h714;
   localparam logic [11:0] EVNT_OFS = 12'h718;

   // =====================================================
   // control fields
   localparam int unsigned LIMIT_LSB = 0;
   localparam int unsigned LIMIT_W   = 14;
   localparam int unsigned MODE_BIT  = 16;
   localparam logic [13:0] LIMIT_RST = 14'h947;
   localparam logic        MODE_RST  = 1'b1;

   // =====================================================
   // status and event fields
   localparam int unsigned ST_HOLD_BIT = 0;
   localparam int unsigned ST_FSM_LSB  = 1;
   localparam int unsigned ST_ELAP_LSB = 8;
   localparam int unsigned ST_REJ_LSB  = 24;
   localparam int unsigned REJ_W       = 8;
   localparam int unsigned EV_W        = 16;
   localparam int unsigned EV_RST_LSB  = 16;

   // =====================================================
   // timing: elapsed time kept in half units of 4 ns
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned COUNT_NS      = 4;
   localparam int unsigned FRAC_BITS     = 1;
   localparam int unsigned ACC_W         = LIMIT_W + FRAC_BITS + 1;
   localparam logic [15:0] STEP =
      16'((CLK_PERIOD_NS << FRAC_BITS) / COUNT_NS);

   // =====================================================
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PEND = 2'b01,
      ST_HOLD = 2'b11
   } lahr_state_t;

   function automatic logic [EV_W-1:0] sat_inc(input logic [EV_W-1:0] v);
      sat_inc = (v == {EV_W{1'b1}}) ? v : v + 16'h0001;
   endfunction : sat_inc
endpackage : lahr_pkg

// ---- lahr_if.sv ----
/*
 holds the carriers between the top, the bus slave and the hold-off counter.
 assumes all parties run on the same clock.
*/
`timescale 1ns/100ps
interface lahr_reg_if;
   import lahr_pkg::*;
   logic              wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [3:0]        sel;
   logic [DATA_W-1:0] rdata;
   modport bus (output wr, addr, wdata, sel, input rdata);
   modport regs (input wr, addr, wdata, sel, output rdata);
endinterface : lahr_reg_if

interface lahr_tmr_if;
   import lahr_pkg::*;
   logic               start;
   logic               run;
   logic [LIMIT_W-1:0] limit;
   logic               expired;
   logic [LIMIT_W-1:0] elapsed;
   modport ctl (output start, run, limit, input expired, elapsed);
   modport tmr (input start, run, limit, output expired, elapsed);
endinterface : lahr_tmr_if

// ---- lahr_wb_slave.sv ----
/*
 holds the classic wishbone slave of the hold-off timer registers.
 assumes a master that holds its request until it samples ack.
*/
`timescale 1ns/100ps
module lahr_wb_slave
   import lahr_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [DATA_W-1:0] wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   output logic      [DATA_W-1:0] wb_dat_o,
   output logic                   wb_ack_o,
   lahr_reg_if.bus                rb
);
   import lahr_pkg::*;

   logic              ack_reg;
   logic [DATA_W-1:0] dat_reg;

   // =====================================================
   // one wait state; ack drops the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= '0;
      end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
         dat_reg <= rb.rdata;
      end
   end

   // write lands on the edge where the master samples ack
   assign rb.wr    = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
   assign rb.addr  = wb_adr_i;
   assign rb.wdata = wb_dat_i;
   assign rb.sel   = wb_sel_i;
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
endmodule : lahr_wb_slave

// ---- lahr_holdoff_cnt.sv ----
/*
 holds the hold-off interval counter, in half units of 4 ns.
 assumes start is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/100ps
module lahr_holdoff_cnt
   import lahr_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   lahr_tmr_if.tmr   tif
);
   import lahr_pkg::*;

   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] goal;

   // limit is read live so a rewrite during hold-off takes hold at once
   assign goal        = {1'b0, tif.limit, 1'b0};
   assign tif.expired = (acc_reg >= goal);
   assign tif.elapsed = acc_reg[LIMIT_W:FRAC_BITS];

   // stops once at or past the goal so the sum never wraps
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_reg <= '0;
      end else if (tif.start) begin
         acc_reg <= '0;
      end else if (tif.run & ~tif.expired) begin
         acc_reg <= acc_reg + STEP[ACC_W-1:0];
      end
   end
endmodule : lahr_holdoff_cnt

// ---- lahr_monitor.sv ----
/*
 checker of the hold-off timer top ports: bus answer, link pulses.
 assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module lahr_monitor
   import lahr_pkg::*;
(
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic                        wb_we_i,
   input wire logic [lahr_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [lahr_pkg::DATA_W-1:0] wb_dat_o,
   input wire logic                        wb_ack_o,
   input wire logic                        l1_req_dllp_i,
   input wire logic                        pm_nak_sent_i,
   input wire logic                        l1_entry_req_o,
   input wire logic                        holdoff_o,
   input wire logic                        dllp_ignored_o
);
   import lahr_pkg::*;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================
   // bus
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_rsvd_read_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == CTRL_OFS
      |-> wb_dat_o[15:14] == 2'h0 && wb_dat_o[31:17] == 15'h0)
      else $error("reserved control bits not zero");
   // ==========================
   // link
   a_entry_from_dllp: assert property (l1_entry_req_o |-> $past(l1_req_dllp_i))
      else $error("entry request without request DLLP");
   a_entry_single: assert property (l1_entry_req_o |=> !l1_entry_req_o)
      else $error("entry request repeated");
   a_hold_from_nak: assert property ($rose(holdoff_o) |-> $past(pm_nak_sent_i))
      else $error("hold-off started without reject");
   a_ignore_in_hold: assert property (
      dllp_ignored_o |-> $past(holdoff_o && l1_req_dllp_i))
      else $error("ignored pulse outside hold-off");
   a_no_entry_held: assert property (dllp_ignored_o |-> !l1_entry_req_o)
      else $error("request recognised during hold-off");
endmodule : lahr_monitor

bind lahr_top lahr_monitor u_lahr_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .l1_req_dllp_i(l1_req_dllp_i),
   .pm_nak_sent_i(pm_nak_sent_i), .l1_entry_req_o(l1_entry_req_o),
   .holdoff_o(holdoff_o), .dllp_ignored_o(dllp_ignored_o));

// ---- lahr_link_partner.sv ----
/*
 link partner model: sends request DLLPs while asked to.
 assumes the port clock; each DLLP is a one-cycle pulse.
*/
`timescale 1ns/100ps
module lahr_link_partner (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       send_i,
   input  wire logic [3:0] gap_i,
   output logic            l1_req_dllp_o
);
   logic fire;
   logic [3:0] gap_reg;
   assign fire = send_i && gap_reg == 4'h0;
   // a real partner keeps repeating its request until it is answered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_reg       <= 4'h0;
         l1_req_dllp_o <= 1'h0;
      end else begin
         l1_req_dllp_o <= fire;
         gap_reg       <= fire ? gap_i : (gap_reg == 4'h0 ? 4'h0 : gap_reg - 4'h1);
      end
   end
endmodule : lahr_link_partner

// ---- test_lahr_top.sv ----
/*
 bench of the hold-off timer: register rows, then link cases.
 assumes the partner model and the bound checker.
*/
`timescale 1ns/100ps
module test_lahr_top;
   import lahr_pkg::*;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;}
      lahr_row_t;
   localparam int N = 8; // ceil(2*100/25) for limit 0x64
   logic        clk_i, rst_i, cyc, we, send, ack_s, nak_s, dllp, ack, ent, hold, ign;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, dato;
   logic [3:0]  sel;
   int          mismatches, n_tests, len;
   lahr_row_t   rows [8] = '{
      '{1'h0, 12'h710, 32'h0, 4'h0, 32'h00010947}, '{1'h1, 12'h710, 32'hFFFFFFFF, 4'hF, 32'h0},
      '{1'h0, 12'h710, 32'h0, 4'h0, 32'h00013FFF}, '{1'h1, 12'h710, 32'h64, 4'h3, 32'h0},
      '{1'h0, 12'h710, 32'h0, 4'h0, 32'h00010064}, '{1'h0, 12'h7FC, 32'h0, 4'h0, 32'h0},
      '{1'h1, 12'h710, 32'h0, 4'h4, 32'h0}, '{1'h0, 12'h710, 32'h0, 4'h0, 32'h00000064}};
   lahr_top u_lahr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dato),
      .wb_ack_o(ack), .l1_req_dllp_i(dllp), .pm_ack_sent_i(ack_s), .pm_nak_sent_i(nak_s),
      .l1_entry_req_o(ent), .holdoff_o(hold), .dllp_ignored_o(ign));
   lahr_link_partner u_lahr_link_partner (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
      .gap_i(4'h3), .l1_req_dllp_o(dllp));
   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (hold === 1'h1) len <= len + 1;
   // ==========================
   // tasks
   task automatic print_verdict;
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic timeout;
      mismatches++;
      print_verdict();
   endtask : timeout
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int i;
      @(posedge clk_i);
      cyc  <= 1'h1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack === 1'h1) break;
      end
      if (i == 20) timeout();
      rdat = dato;
      cyc <= 1'h0;
   endtask : wb
   task automatic dllp_once(input logic e);
      int i;
      send <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (dllp === 1'h1) break;
      end
      if (i == 20) timeout();
      send <= 1'h0;
      #1;
      chk("entry", {31'h0, e}, {31'h0, ent});
      chk("ignored", {31'h0, !e}, {31'h0, ign});
   endtask : dllp_once
   task automatic pm(input logic n);
      @(posedge clk_i);
      nak_s <= n;
      ack_s <= !n;
      @(posedge clk_i);
      nak_s <= 1'h0;
      ack_s <= 1'h0;
      #1;
      chk("holdoff", {31'h0, n}, {31'h0, hold});
   endtask : pm
   task automatic wait_fall;
      int i;
      for (i = 0; i < 2000 && hold === 1'h1; i++) @(posedge clk_i);
      if (i == 2000) timeout();
      #1;
   endtask : wait_fall
   // ==========================
   // sequence
   initial begin
      {cyc, we, send, ack_s, nak_s} = 5'h0;
      {adr, wdat, sel} = 48'h0;
      mismatches = 0;
      n_tests    = 0;
      len        = 0;
      rst_i      = 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (rows[k]) begin
         wb(rows[k].w, rows[k].a, rows[k].d, rows[k].s);
         if (!rows[k].w) chk("ctrl", rows[k].e, rdat);
      end
      // mode 0: a request during hold-off counts anew from zero
      dllp_once(1'h1);
      len = 0;
      pm(1'h1);
      dllp_once(1'h0);
      wait_fall();
      chk("len_mode0", 32'(len > N + 1), 32'h1);
      // mode 1: the same request is only ignored
      wb(1'h1, 12'h710, 32'h00010064, 4'h4);
      dllp_once(1'h1);
      len = 0;
      pm(1'h1);
      dllp_once(1'h0);
      wait_fall();
      chk("len_mode1", 32'(len >= N && len <= N + 1), 32'h1);
      dllp_once(1'h1);
      pm(1'h0);
      dllp_once(1'h1);
      // event and status words after one restart, one ignore and two rejects
      wb(1'h0, 12'h718, 32'h0, 4'h0);
      chk("evnt", 32'h00010001, rdat);
      wb(1'h0, 12'h714, 32'h0, 4'h0);
      chk("stat", 32'h02006402, rdat);
      wb(1'h1, 12'h718, 32'h0, 4'hF);
      wb(1'h0, 12'h718, 32'h0, 4'h0);
      chk("evnt_clr", 32'h0, rdat);
      // reset while a request is pending
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, 12'h710, 32'h0, 4'h0);
      chk("ctrl_rst", 32'h00010947, rdat);
      print_verdict();
   end
endmodule : test_lahr_top
